// *** rtl/tid_defs.svh ***
`ifndef TID_DEFS_SVH
`define TID_DEFS_SVH
// Function
// - Invalidate alias chosen only on matching fields
// - First opcode field is 3-bit, 0..7
// - First register field is 0..15
// - Second register field is 0..15
// - Second opcode field is 3-bit, 0..7
// - Level-1 inner-shared group, six operations
// - Level-1 local group, same six operations
// - Inner stage-2 address and last-level forms
// - Level-2 inner-shared group, five operations
// - Local stage-2 address and last-level forms
// - Level-2 local group, five operations
// - Level-3 inner and local, three operations
// - Outer option adds level-1 outer group
// - Outer option adds level-2 and level-3 groups
// - Outer option adds outer stage-2 forms
// - Range option adds level-1 range groups
// - Range option adds stage-2 range forms
// - Range option adds level-2/3 range addresses
// - Fast-variant option mirrors all forms, register 1001

// ****************************************
// Field widths
// ****************************************
`define TID_OP_W       3
`define TID_CR_W       4

// ****************************************
// Field encodings
// ****************************************
`define TID_FOP_L1     3'h0
`define TID_FOP_L2     3'h4
`define TID_FOP_L3     3'h6
`define TID_CRN_BASE   4'h8
`define TID_CRN_NXS    4'h9
`define TID_CRM_S2IS   4'h0
`define TID_CRM_OS     4'h1
`define TID_CRM_RIS    4'h2
`define TID_CRM_IS     4'h3
`define TID_CRM_S2LOC  4'h4
`define TID_CRM_ROS    4'h5
`define TID_CRM_RLOC   4'h6
`define TID_CRM_LOC    4'h7
`endif

// *** rtl/tid_group_map.sv ***
`timescale 1ns/1ps
`include "tid_defs.svh"
// ****************************************
// Second-opcode mapper for one group
// ****************************************
module tid_group_map (
	input  wire logic [2:0] second_opcode_field,
	input  wire logic [1:0] grp,
	output tid_pkg::tid_kind_t kind
);
	// Group 0: six level-1 ops; 1: five level-2 ops; 2: three level-3 ops; 3: range level-1
	always_comb begin
		kind = tid_pkg::TID_OP_NONE;
		unique case (grp)
			2'h0: begin
				unique case (second_opcode_field)
					3'h0: kind = tid_pkg::TID_OP_ALL;
					3'h1: kind = tid_pkg::TID_OP_ADDR;
					3'h2: kind = tid_pkg::TID_OP_SPACE_ID;
					3'h3: kind = tid_pkg::TID_OP_ADDR_ANY_ID;
					3'h5: kind = tid_pkg::TID_OP_LAST_ADDR;
					3'h7: kind = tid_pkg::TID_OP_LAST_ANY_ID;
					default: kind = tid_pkg::TID_OP_NONE;
				endcase
			end
			2'h1: begin
				unique case (second_opcode_field)
					3'h0: kind = tid_pkg::TID_OP_ALL;
					3'h1: kind = tid_pkg::TID_OP_ADDR;
					3'h4: kind = tid_pkg::TID_OP_ALL_HYP_L1;
					3'h5: kind = tid_pkg::TID_OP_LAST_ADDR;
					3'h6: kind = tid_pkg::TID_OP_GUEST_BOTH;
					default: kind = tid_pkg::TID_OP_NONE;
				endcase
			end
			2'h2: begin
				unique case (second_opcode_field)
					3'h0: kind = tid_pkg::TID_OP_ALL;
					3'h1: kind = tid_pkg::TID_OP_ADDR;
					3'h5: kind = tid_pkg::TID_OP_LAST_ADDR;
					default: kind = tid_pkg::TID_OP_NONE;
				endcase
			end
			2'h3: begin
				unique case (second_opcode_field)
					3'h1: kind = tid_pkg::TID_OP_RANGE_ADDR;
					3'h3: kind = tid_pkg::TID_OP_RANGE_ANY_ID;
					3'h5: kind = tid_pkg::TID_OP_RANGE_LAST;
					3'h7: kind = tid_pkg::TID_OP_RANGE_LAST_ANY;
					default: kind = tid_pkg::TID_OP_NONE;
				endcase
			end
		endcase
	end
endmodule : tid_group_map

// *** rtl/tid_pkg.sv ***
package tid_pkg;
	// Scope of an invalidation
	typedef enum logic [1:0] {
		TID_SH_NONE,
		TID_SH_INNER,
		TID_SH_OUTER,
		TID_SH_LOCAL
	} tid_share_t;

	// Named operation classes
	typedef enum logic [3:0] {
		TID_OP_NONE,
		TID_OP_ALL,
		TID_OP_ADDR,
		TID_OP_SPACE_ID,
		TID_OP_ADDR_ANY_ID,
		TID_OP_LAST_ADDR,
		TID_OP_LAST_ANY_ID,
		TID_OP_S2_ADDR,
		TID_OP_S2_LAST,
		TID_OP_ALL_HYP_L1,
		TID_OP_GUEST_BOTH,
		TID_OP_RANGE_ADDR,
		TID_OP_RANGE_ANY_ID,
		TID_OP_RANGE_LAST,
		TID_OP_RANGE_LAST_ANY,
		TID_OP_RANGE_S2
	} tid_kind_t;

	// Full decode result
	typedef struct packed {
		logic       hit;
		logic [1:0] level;
		tid_share_t share;
		tid_kind_t  kind;
		logic       s2_last;
		logic       fast;
	} tid_res_t;
endpackage : tid_pkg

// *** rtl/tid_rst_sync.sv ***
`timescale 1ns/1ps
// ****************************************
// Reset release synchroniser
// ****************************************
module tid_rst_sync (
	input  wire logic clk,
	input  wire logic rstn,
	output logic      rstn_sync
);
	// Two-stage release; assert is immediate
	typedef struct packed {
		logic s1;
		logic s2;
	} tid_rs_t;
	tid_rs_t st_ff;
	tid_rs_t nxt_st;

	// Shift a one in after release
	always_comb begin
		nxt_st.s1 = 1'b1;
		nxt_st.s2 = st_ff.s1;
	end

	// Registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rstn_sync = st_ff.s2;
endmodule : tid_rst_sync

// *** rtl/tlbi_op_decode.sv ***
`timescale 1ns/1ps
`include "tid_defs.svh"
// ****************************************
// Invalidate-alias decoder, one cycle latency
// ****************************************
module tlbi_op_decode #(
	parameter bit OUTER_SHAREABLE_OPTION = 1'b1,
	parameter bit ADDRESS_RANGE_OPTION   = 1'b1,
	parameter bit NON_EXTRA_SLOW_OPTION  = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       in_valid,
	input  wire logic [2:0] first_opcode_field,
	input  wire logic [3:0] first_crn_field,
	input  wire logic [3:0] second_crm_field,
	input  wire logic [2:0] second_opcode_field,
	output logic            out_valid,
	output logic            is_invalidate,
	output logic [1:0]      inv_level,
	output logic [1:0]      inv_share,
	output logic [3:0]      inv_kind,
	output logic            inv_s2_last,
	output logic            inv_fast
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic              vld;
		tid_pkg::tid_res_t res;
	} tid_state_t;

	tid_state_t         st_ff;      // Registered result
	tid_state_t         nxt_st;     // Next result
	logic               rstn_sync;  // Released reset
	logic [1:0]         grp_sel;    // Group chosen for mapper
	tid_pkg::tid_kind_t grp_kind;   // Mapper answer

	// Reset release
	tid_rst_sync u_rst (
		.clk       (clk),
		.rstn      (rstn),
		.rstn_sync (rstn_sync)
	);

	// Shared second-opcode mapper
	tid_group_map u_map (
		.second_opcode_field (second_opcode_field),
		.grp                 (grp_sel),
		.kind                (grp_kind)
	);

	// Pick the mapper group from first opcode and second register
	function automatic logic [1:0] pick_grp(input logic [2:0] fop, input logic [3:0] crm);
		logic [1:0] g;
		g = 2'h0;
		if (fop == `TID_FOP_L2) begin
			g = 2'h1;
		end else if (fop == `TID_FOP_L3) begin
			g = 2'h2;
		end else if (crm == `TID_CRM_RIS || crm == `TID_CRM_ROS || crm == `TID_CRM_RLOC) begin
			g = 2'h3;
		end
		return g;
	endfunction : pick_grp

	// Scope of a range group; one copy keeps level-1 and level-2/3 in step
	function automatic tid_pkg::tid_share_t range_share(input logic [3:0] crm);
		tid_pkg::tid_share_t s;
		s = tid_pkg::TID_SH_LOCAL;
		if (crm == `TID_CRM_RIS) begin
			s = tid_pkg::TID_SH_INNER;
		end else if (crm == `TID_CRM_ROS) begin
			s = tid_pkg::TID_SH_OUTER;
		end
		return s;
	endfunction : range_share

	assign grp_sel = pick_grp(first_opcode_field, second_crm_field);

	// ****************************************
	// Decode
	// ****************************************
	// Full 3/4/4/3-bit compare; every field value is legal input
	always_comb begin
		tid_pkg::tid_res_t r;
		logic crn_ok;
		r = '0;
		crn_ok = 1'b0;
		// Base register, or fast-variant register when present
		if (first_crn_field == `TID_CRN_BASE) begin
			crn_ok = 1'b1;
		end else if (first_crn_field == `TID_CRN_NXS && NON_EXTRA_SLOW_OPTION) begin
			crn_ok = 1'b1;
			r.fast = 1'b1;
		end
		if (crn_ok) begin
			unique case (first_opcode_field)
				`TID_FOP_L1: begin
					r.level = 2'h1;
					unique case (second_crm_field)
						`TID_CRM_IS: begin
							r.kind = grp_kind;
							r.share = tid_pkg::TID_SH_INNER;
						end
						`TID_CRM_LOC: begin
							r.kind = grp_kind;
							r.share = tid_pkg::TID_SH_LOCAL;
						end
						`TID_CRM_OS: begin
							if (OUTER_SHAREABLE_OPTION) begin
								r.kind = grp_kind;
								r.share = tid_pkg::TID_SH_OUTER;
							end
						end
						`TID_CRM_RIS, `TID_CRM_ROS, `TID_CRM_RLOC: begin
							if (ADDRESS_RANGE_OPTION) begin
								r.kind = grp_kind;
								r.share = range_share(second_crm_field);
							end
						end
						default: r.kind = tid_pkg::TID_OP_NONE;
					endcase
				end
				`TID_FOP_L2, `TID_FOP_L3: begin
					r.level = (first_opcode_field == `TID_FOP_L2) ? 2'h2 : 2'h3;
					unique case (second_crm_field)
						`TID_CRM_IS: begin
							r.kind = grp_kind;
							r.share = tid_pkg::TID_SH_INNER;
						end
						`TID_CRM_LOC: begin
							r.kind = grp_kind;
							r.share = tid_pkg::TID_SH_LOCAL;
						end
						`TID_CRM_OS: begin
							if (OUTER_SHAREABLE_OPTION) begin
								r.kind = grp_kind;
								r.share = tid_pkg::TID_SH_OUTER;
							end
						end
						`TID_CRM_RIS, `TID_CRM_ROS, `TID_CRM_RLOC: begin
							if (ADDRESS_RANGE_OPTION && second_opcode_field[1:0] == 2'h1) begin
								r.kind = second_opcode_field[2] ? tid_pkg::TID_OP_RANGE_LAST
								                                : tid_pkg::TID_OP_RANGE_ADDR;
								r.share = range_share(second_crm_field);
							end
						end
						`TID_CRM_S2IS: begin
							// Stage-2 forms exist only at level 2
							if (first_opcode_field == `TID_FOP_L2) begin
								if (second_opcode_field == 3'h1 || second_opcode_field == 3'h5) begin
									r.kind = tid_pkg::TID_OP_S2_ADDR;
									r.s2_last = second_opcode_field[2];
									r.share = tid_pkg::TID_SH_INNER;
								end else if (ADDRESS_RANGE_OPTION && (second_opcode_field == 3'h2 ||
								             second_opcode_field == 3'h6)) begin
									r.kind = tid_pkg::TID_OP_RANGE_S2;
									r.s2_last = second_opcode_field[2];
									r.share = tid_pkg::TID_SH_INNER;
								end
							end
						end
						`TID_CRM_S2LOC: begin
							if (first_opcode_field == `TID_FOP_L2) begin
								if (second_opcode_field == 3'h1 || second_opcode_field == 3'h5) begin
									r.kind = tid_pkg::TID_OP_S2_ADDR;
									r.s2_last = second_opcode_field[2];
									r.share = tid_pkg::TID_SH_LOCAL;
								end else if (OUTER_SHAREABLE_OPTION && (second_opcode_field == 3'h0 ||
								             second_opcode_field == 3'h4)) begin
									r.kind = tid_pkg::TID_OP_S2_ADDR;
									r.s2_last = second_opcode_field[2];
									r.share = tid_pkg::TID_SH_OUTER;
								end else if (ADDRESS_RANGE_OPTION && second_opcode_field[1]) begin
									r.kind = tid_pkg::TID_OP_RANGE_S2;
									r.s2_last = second_opcode_field[2];
									r.share = second_opcode_field[0] ? tid_pkg::TID_SH_OUTER
									                                 : tid_pkg::TID_SH_LOCAL;
								end
							end
						end
						default: r.kind = tid_pkg::TID_OP_NONE;
					endcase
				end
				default: r.kind = tid_pkg::TID_OP_NONE;
			endcase
		end
		// Unlisted or option-gated codes give a miss with every field cleared
		r.hit = (r.kind != tid_pkg::TID_OP_NONE);
		if (!r.hit) begin
			r = '0;
		end
		nxt_st.vld = in_valid;
		nxt_st.res = in_valid ? r : '0;
	end

	// ****************************************
	// Registers
	// ****************************************
	// Result stage; one flop set keeps timing predictable
	always_ff @(posedge clk or negedge rstn_sync) begin
		if (!rstn_sync) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs all from flops
	assign out_valid     = st_ff.vld;
	assign is_invalidate = st_ff.res.hit;
	assign inv_level     = st_ff.res.level;
	assign inv_share     = st_ff.res.share;
	assign inv_kind      = st_ff.res.kind;
	assign inv_s2_last   = st_ff.res.s2_last;
	assign inv_fast      = st_ff.res.fast;
endmodule : tlbi_op_decode

// *** sim/tid_decode_properties.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checks of the decoder
// ****************************************
module tid_decode_props #(
	parameter bit OUTER_SHAREABLE_OPTION = 1'b1,
	parameter bit ADDRESS_RANGE_OPTION   = 1'b1,
	parameter bit NON_EXTRA_SLOW_OPTION  = 1'b1
) (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       in_valid,
	input wire logic [2:0] first_opcode_field,
	input wire logic [3:0] first_crn_field,
	input wire logic [3:0] second_crm_field,
	input wire logic [2:0] second_opcode_field,
	input wire logic       out_valid,
	input wire logic       is_invalidate,
	input wire logic [1:0] inv_level,
	input wire logic [1:0] inv_share,
	input wire logic [3:0] inv_kind,
	input wire logic       inv_s2_last,
	input wire logic       inv_fast
);
	logic sop_hi; // Last-level bit of the second opcode
	assign sop_hi = second_opcode_field[2];
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	valid_follow_a: assert property (in_valid |=> out_valid) else $error("answer missing");
	valid_quiet_a: assert property (!in_valid |=> !out_valid) else $error("answer without request");
	miss_zero_a: assert property (out_valid && !is_invalidate |->
		{inv_level, inv_share, inv_kind, inv_s2_last, inv_fast} == 10'h0) else $error("fields set on a miss");
	fop_odd_a: assert property (in_valid && first_opcode_field[0] |=> !is_invalidate)
		else $error("odd op hit");
	crn_range_a: assert property (in_valid && !(first_crn_field inside {4'h8, 4'h9}) |=> !is_invalidate)
		else $error("bad crn hit");
	crm_high_a: assert property (in_valid && second_crm_field[3] |=> !is_invalidate)
		else $error("crm hit");
	level_map_a: assert property (out_valid && is_invalidate |-> inv_level ==
		(($past(first_opcode_field) == 3'h0) ? 2'h1 : ($past(first_opcode_field) == 3'h4) ? 2'h2 : 2'h3))
		else $error("wrong level");
	fast_flag_a: assert property (out_valid |->
		inv_fast == (is_invalidate && $past(first_crn_field) == 4'h9)) else $error("wrong fast flag");
	fast_gate_a: assert property (in_valid && first_crn_field == 4'h9 &&
		!NON_EXTRA_SLOW_OPTION |=> !is_invalidate) else $error("fast form without option");
	outer_gate_a: assert property (in_valid && second_crm_field == 4'h1 &&
		!OUTER_SHAREABLE_OPTION |=> !is_invalidate) else $error("outer form without option");
	range_gate_a: assert property (in_valid && second_crm_field inside {4'h2, 4'h5, 4'h6} &&
		!ADDRESS_RANGE_OPTION |=> !is_invalidate) else $error("range form without option");
	s2_last_a: assert property (out_valid && is_invalidate |->
		inv_s2_last == (inv_kind inside {4'h7, 4'hF} && $past(sop_hi))) else $error("wrong last-level flag");
	l1_all_a: assert property (in_valid && {first_opcode_field, first_crn_field, second_crm_field,
		second_opcode_field} == 14'h0418 |=> is_invalidate && inv_kind == 4'h1 && inv_share == 2'h1)
		else $error("level-1 all missed");
	fast_hit_c: cover property (out_valid && is_invalidate && inv_fast);
	miss_c: cover property (out_valid && !is_invalidate);
	range_s2_c: cover property (out_valid && inv_kind == 4'hF && inv_s2_last);
endmodule : tid_decode_props

bind tlbi_op_decode tid_decode_props #(.OUTER_SHAREABLE_OPTION(OUTER_SHAREABLE_OPTION),
	.ADDRESS_RANGE_OPTION(ADDRESS_RANGE_OPTION), .NON_EXTRA_SLOW_OPTION(NON_EXTRA_SLOW_OPTION))
	tid_decode_props_i (.clk(clk), .rstn(rstn), .in_valid(in_valid), .first_opcode_field(first_opcode_field),
	.first_crn_field(first_crn_field), .second_crm_field(second_crm_field),
	.second_opcode_field(second_opcode_field), .out_valid(out_valid), .is_invalidate(is_invalidate),
	.inv_level(inv_level), .inv_share(inv_share), .inv_kind(inv_kind), .inv_s2_last(inv_s2_last),
	.inv_fast(inv_fast));

// *** sim/tid_fetch_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Instruction feed of the pipeline
// ****************************************
module tid_fetch_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        req_v,
	input  wire logic [13:0] req_f,
	output logic             in_valid,
	output logic [13:0]      fld
);
	typedef struct packed {
		logic [13:0] last; // Last fields sent
	} tid_fm_t;
	tid_fm_t st_ff;
	tid_fm_t nxt_st;
	// Keep the last request so idle fields never repeat it
	always_comb begin
		nxt_st = st_ff;
		if (req_v) begin
			nxt_st.last = req_f;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign in_valid = req_v;
	// Idle fields are the inverse, a stale match would hide a sampling slip
	assign fld = req_v ? req_f : ~st_ff.last;
endmodule : tid_fetch_model

// *** sim/tlb_invalidate_op_decode_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tlb_invalidate_op_decode_tb;
	localparam logic [31:0] T1 = 32'h6050_4321; // Level-1 kinds by second opcode
	localparam logic [31:0] T2 = 32'h0A59_0021; // Level-2 kinds
	localparam logic [31:0] T3 = 32'h0050_0021; // Level-3 kinds
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        req_v = 1'b0;
	logic [13:0] req_f = 14'h0;
	logic [13:0] fld;
	logic        in_valid;
	logic        ov_on, ov_off;
	wire  [10:0] r_on, r_off; // {hit, level, share, kind, s2_last, fast}; nets, one port per slice
	int          bad_count = 0;
	int          n_checks = 0;
	always #12.5 clk = ~clk;
	tid_fetch_model tid_fetch_model_i (.clk(clk), .rstn(rstn), .req_v(req_v), .req_f(req_f), .in_valid(in_valid),
		.fld(fld));
	tlbi_op_decode tlbi_op_decode_i (.clk(clk), .rstn(rstn), .in_valid(in_valid), .first_opcode_field(fld[13:11]),
		.first_crn_field(fld[10:7]), .second_crm_field(fld[6:3]), .second_opcode_field(fld[2:0]), .out_valid(ov_on),
		.is_invalidate(r_on[10]), .inv_level(r_on[9:8]), .inv_share(r_on[7:6]), .inv_kind(r_on[5:2]),
		.inv_s2_last(r_on[1]), .inv_fast(r_on[0]));
	// Second copy with every option absent
	tlbi_op_decode #(.OUTER_SHAREABLE_OPTION(1'b0), .ADDRESS_RANGE_OPTION(1'b0), .NON_EXTRA_SLOW_OPTION(1'b0))
		tlbi_op_decode_off_i (.clk(clk), .rstn(rstn), .in_valid(in_valid), .first_opcode_field(fld[13:11]),
		.first_crn_field(fld[10:7]), .second_crm_field(fld[6:3]), .second_opcode_field(fld[2:0]),
		.out_valid(ov_off), .is_invalidate(r_off[10]), .inv_level(r_off[9:8]), .inv_share(r_off[7:6]),
		.inv_kind(r_off[5:2]), .inv_s2_last(r_off[1]), .inv_fast(r_off[0]));
	// Expected result for one field set
	function automatic logic [10:0] ref_dec(input logic [13:0] f, input bit on);
		logic [2:0] o1, o2;
		logic [3:0] n, m, k;
		logic [1:0] sh, lv;
		logic       s2, fa;
		{o1, n, m, o2} = f;
		k = 4'h0;
		s2 = 1'b0;
		fa = (n == 4'h9);
		lv = (o1 == 3'h0) ? 2'h1 : (o1 == 3'h4) ? 2'h2 : 2'h3;
		if (!(n == 4'h8 || (fa && on))) return 11'h0;
		case (m)
			4'h1: sh = on ? 2'h2 : 2'h0;
			4'h2: sh = {1'b0, on};
			4'h3: sh = 2'h1;
			4'h5: sh = {on, 1'b0};
			4'h6: sh = {on, on};
			4'h7: sh = 2'h3;
			default: sh = 2'h0;
		endcase
		if (m == 4'h0 || m == 4'h4) begin
			s2 = o2[2];
			case (o2[1:0])
				2'h1: k = 4'h7;
				2'h0: k = (m[2] && on) ? 4'h7 : 4'h0;
				2'h2: k = on ? 4'hF : 4'h0;
				default: k = (m[2] && on) ? 4'hF : 4'h0;
			endcase
			sh = (o2[0] ~^ o2[1]) ? 2'h2 : (m[2] ? 2'h3 : 2'h1);
			if (o1 != 3'h4) k = 4'h0;
		end else if (m inside {4'h2, 4'h5, 4'h6}) begin
			if (o1 == 3'h0 && o2[0]) k = 4'hB + {2'h0, o2[2:1]};
			else if ((o1 == 3'h4 || o1 == 3'h6) && o2[1:0] == 2'h1) k = 4'hB + {1'b0, o2[2], 1'b0};
		end else if (o1 == 3'h0) k = T1[{o2, 2'h0} +: 4];
		else if (o1 == 3'h4) k = T2[{o2, 2'h0} +: 4];
		else if (o1 == 3'h6) k = T3[{o2, 2'h0} +: 4];
		if (k == 4'h0 || sh == 2'h0) return 11'h0;
		return {1'b1, lv, sh, k, s2, fa};
	endfunction : ref_dec
	// Compare both copies against the previous request
	task automatic judge(input logic pv, input logic [13:0] pf);
		`CHK("valid_on", pv, ov_on)
		`CHK("valid_off", pv, ov_off)
		if (pv) begin
			`CHK("result_on", ref_dec(pf, 1'b1), r_on)
			`CHK("result_off", ref_dec(pf, 1'b0), r_off)
		end
	endtask : judge
	// Reset, outputs cleared at once, released after ten cycles
	task automatic t_reset();
		req_v = 1'b0;
		rstn = 1'b0;
		@(negedge clk);
		`CHK("reset_clear", 24'h0, {ov_on, r_on, ov_off, r_off})
		repeat (9) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
	endtask : t_reset
	// Every field combination, back to back
	task automatic t_sweep();
		logic        pv = 1'b0;
		logic [13:0] pf = 14'h0;
		for (int i = 0; i < 16384; i++) begin
			@(negedge clk);
			judge(pv, pf);
			req_v = 1'b1;
			req_f = i[13:0];
			pv = 1'b1;
			pf = i[13:0];
		end
		@(negedge clk);
		judge(pv, pf);
		req_v = 1'b0;
		@(negedge clk);
		judge(1'b0, pf);
	endtask : t_sweep
	// Single requests between idle cycles
	task automatic t_gaps();
		logic [13:0] c [3] = '{14'h24A7, 14'h343D, 14'h0418};
		foreach (c[j]) begin
			req_v = 1'b1;
			req_f = c[j];
			@(negedge clk);
			judge(1'b1, c[j]);
			req_v = 1'b0;
			@(negedge clk);
			judge(1'b0, c[j]);
		end
	endtask : t_gaps
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		t_reset();
		t_sweep();
		t_gaps();
		t_reset();
		t_gaps();
		summarize();
	end
	// Hang guard, about two and a half times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		summarize();
	end
endmodule : tlb_invalidate_op_decode_tb
